// >>> verilog/adcts_pkg.sv
// Purpose: Shared constants and types for the converter trigger sequencer.
// Assumes: APB byte addressing, 32-bit data, one register per aligned word.
// Notes:   Function
// Function
// RULE_01 - The capacitor array is discharged before every sample.
// RULE_02 - A compare trigger starts work only in compare mode 1011 with the converter on.
// RULE_03 - An accepted trigger sets the go flag just like a software start.
// RULE_04 - Every compare trigger clears the linked timer counter; the code clears it only for triggers in compare mode 1011.
// RULE_05 - With the converter off the trigger is ignored but still clears the timer.
// RULE_06 - Software picks the channel and acquisition timing before any trigger.
// RULE_07 - Acquisition code 010 gives 4 bit periods of automatic acquisition.
// RULE_08 - Unimplemented control register bits read as zero.
// RULE_09 - The result sits in a high byte and a low byte register.
// RULE_10 - Completion clears go, sets the done flag and resumes sampling.
// RULE_11 - Clearing go mid-conversion aborts and keeps the old result.
// RULE_12 - A 10-bit conversion takes eleven bit periods.
// RULE_13 - Acquisition code 000 converts at once when go is set.
// RULE_14 - The justify bit aligns the result left or right, spare bits zero.
// RULE_15 - A trigger during acquisition or conversion does not restart it.
package adcts_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_RES_HI   = 8'h00;
  localparam logic [7:0] OFS_RES_LO   = 8'h04;
  localparam logic [7:0] OFS_RUN      = 8'h08;
  localparam logic [7:0] OFS_PINREF   = 8'h0c;
  localparam logic [7:0] OFS_TIMING   = 8'h10;
  localparam logic [7:0] OFS_CMPMODE  = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // Field positions in the run control and interrupt registers
  localparam int RUN_ON_BIT  = 0;
  localparam int RUN_GO_BIT  = 1;
  localparam int RUN_CHS_LSB = 2;
  localparam int DONE_BIT    = 0;

  // Compare mode that carries a special event
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;

  // Sequence lengths in bit periods
  localparam int          RES_WIDTH   = 10;
  localparam logic [4:0]  CONV_TADS   = 5'h0b;
  localparam logic [4:0]  REST_TADS   = 5'h02;
  localparam logic [4:0]  DISCH_TADS  = 5'h01;
  localparam logic [2:0]  ACQ_MANUAL  = 3'h0;
  localparam logic [6:0]  RC_DIV_DEF  = 7'h64;

  // Reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  typedef struct packed {
    logic [1:0] vref;
    logic [3:0] pins;
  } adcts_pinref_t;

  typedef struct packed {
    logic       justify;
    logic [2:0] acqt;
    logic [2:0] adcs;
  } adcts_timing_t;

  typedef enum logic [2:0] {
    S_OFF, S_DISCH, S_SAMPLE, S_ACQ, S_CONV, S_REST
  } adcts_state_t;

  // Acquisition length in bit periods per code
  function automatic logic [4:0] adcts_acq_tads(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h00;
    unique case (code)
      3'h0: n = 5'h00;
      3'h1: n = 5'h02;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0c;
      3'h6: n = 5'h10;
      3'h7: n = 5'h14;
    endcase
    return n;
  endfunction : adcts_acq_tads

  // Clock cycles per bit period per code
  function automatic logic [6:0] adcts_tad_div(input logic [2:0] code,
                                               input logic [6:0] rc_div);
    logic [6:0] d;
    d = rc_div;
    unique case (code)
      3'h0: d = 7'h02;
      3'h4: d = 7'h04;
      3'h1: d = 7'h08;
      3'h5: d = 7'h10;
      3'h2: d = 7'h20;
      3'h6: d = 7'h40;
      3'h3, 3'h7: d = rc_div;
    endcase
    return d;
  endfunction : adcts_tad_div

endpackage : adcts_pkg

// >>> verilog/adcts_tad_div.sv
// Purpose: Bit period tick generator.
// Assumes: div of at least 2.
// Notes:   Clear realigns the period to a state change.
`timescale 1ns/1ns
module adcts_tad_div
  import adcts_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic [6:0] div,
  output logic            tick
);

  logic [6:0] cnt;
  wire        wrap = (cnt >= div - 7'h01); // A shortened div still wraps at once

  // Count clocks, pulse once per period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 7'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= (clear || wrap) ? 7'h00 : cnt + 7'h01;
      tick <= wrap && !clear;
    end
  end

endmodule : adcts_tad_div

// >>> verilog/adcts_sar.sv
// Purpose: Successive approximation register, one bit per tick.
// Assumes: cmp_hi high when the input is above the trial code.
// Notes:   Done pulses on the tick after the last bit decision.
`timescale 1ns/1ns
module adcts_sar
  import adcts_pkg::*;
#(
  parameter int W = RES_WIDTH
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic         tick,
  input  wire logic         cmp_hi,
  output logic [W-1:0]      trial,
  output logic [W-1:0]      result,
  output logic              done
);

  logic [W-1:0] mask;
  logic         busy;
  wire  [W-1:0] keep = cmp_hi ? mask : '0;
  wire  [W-1:0] next_trial = (trial & ~mask) | keep | (mask >> 1);

  // Walk the mask from the top bit down, then finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial  <= '0;
      mask   <= '0;
      result <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        mask <= '0;
      end else if (start) begin
        busy  <= 1'b1;
        mask  <= {1'b1, {(W-1){1'b0}}};
        trial <= {1'b1, {(W-1){1'b0}}};
      end else if (busy && tick) begin
        if (mask != '0) begin
          trial <= next_trial;
          mask  <= mask >> 1;
        end else begin
          result <= trial;
          busy   <= 1'b0;
          done   <= 1'b1; // RULE_12
        end
      end
    end
  end

endmodule : adcts_sar

// >>> verilog/adcts_top.sv
// Purpose: Converter control with APB registers and compare trigger start.
// Assumes: special_event is a one-cycle pulse on pclk; cmp_hi_async is analog.
// Notes:   Zero-wait APB is not used; every access takes one wait state.
//          Bit periods under 4 clocks outrun the trial code to comparator sync path.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
module adcts_top
  import adcts_pkg::*;
#(
  parameter logic [6:0] RC_DIV = RC_DIV_DEF
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq,
  input  wire logic         special_event,
  output logic              timer_clear,
  input  wire logic         cmp_hi_async,
  output logic              discharge,
  output logic              sample_en,
  output logic [3:0]        channel,
  output logic [1:0]        vref_sel,
  output logic [3:0]        pin_cfg,
  output logic [9:0]        dac_code
);

  // Software-visible state
  logic [7:0]     res_hi;
  logic [7:0]     res_lo;
  logic [3:0]     chs;
  logic           conv_on;
  logic           go;
  adcts_pinref_t  pinref;
  adcts_timing_t  timing;
  logic [3:0]     cmp_mode;
  logic           done_flag;
  logic           done_mask;

  // Sequencer state
  adcts_state_t   state;
  adcts_state_t   next_state;
  logic [4:0]     tad_cnt;
  logic           tad_tick;
  logic           cmp_meta;
  logic           cmp_sync;
  logic [9:0]     sar_trial;
  logic [9:0]     sar_result;
  logic           sar_done;

  // APB phase decode
  wire acc       = psel && penable;
  wire capture   = acc && !pready;
  wire fin       = acc && pready;
  wire sel_hi    = (paddr == OFS_RES_HI);
  wire sel_lo    = (paddr == OFS_RES_LO);
  wire sel_run   = (paddr == OFS_RUN);
  wire sel_pin   = (paddr == OFS_PINREF);
  wire sel_tim   = (paddr == OFS_TIMING);
  wire sel_cmp   = (paddr == OFS_CMPMODE);
  wire sel_stat  = (paddr == OFS_IRQ_STAT);
  wire sel_mask  = (paddr == OFS_IRQ_MASK);
  wire hit       = sel_hi | sel_lo | sel_run | sel_pin
                 | sel_tim | sel_cmp | sel_stat | sel_mask;
  wire wr        = fin && pwrite && hit;
  wire rd_stat   = fin && !pwrite && sel_stat;

  // Read data, spare bits as zero
  wire [31:0] rd_run  = {26'h0, chs, go, conv_on};                  // RULE_08
  wire [31:0] rd_pin  = {26'h0, pinref};                            // RULE_08
  wire [31:0] rd_tim  = {24'h0, timing.justify, 1'b0,
                         timing.acqt, timing.adcs};                 // RULE_08
  wire [31:0] rd_mux  = sel_hi   ? {24'h0, res_hi}   :
                        sel_lo   ? {24'h0, res_lo}   :
                        sel_run  ? rd_run            :
                        sel_pin  ? rd_pin            :
                        sel_tim  ? rd_tim            :
                        sel_cmp  ? {28'h0, cmp_mode} :
                        sel_stat ? {31'h0, done_flag} :
                        sel_mask ? {31'h0, done_mask} : 32'h0;

  // Trigger qualification
  wire trig_mode   = special_event && (cmp_mode == CMP_MODE_SPECIAL);
  wire trig_accept = trig_mode && conv_on;                          // RULE_02

  // Go flag set and clear terms
  wire sw_go_set   = wr && sel_run && pwdata[RUN_GO_BIT];
  wire sw_go_clr   = wr && sel_run && !pwdata[RUN_GO_BIT];
  wire next_on     = (wr && sel_run) ? pwdata[RUN_ON_BIT] : conv_on;
  wire conv_end    = (state == S_CONV) && sar_done && go;
  wire go_set      = trig_accept || sw_go_set;                      // RULE_03
  wire next_go     = next_on && (go_set || (go && !sw_go_clr && !conv_end));

  // Sequencer timing
  wire [4:0] acq_len  = adcts_acq_tads(timing.acqt);                 // RULE_07
  wire [6:0] div_len  = adcts_tad_div(timing.adcs, RC_DIV);
  wire       state_chg = (state != next_state);
  wire       acq_skip  = (timing.acqt == ACQ_MANUAL);
  wire       tad_last_disch = tad_tick && (tad_cnt == DISCH_TADS - 5'h01);
  wire       tad_last_rest  = tad_tick && (tad_cnt == REST_TADS - 5'h01);
  wire       tad_last_acq   = tad_tick && (tad_cnt == acq_len - 5'h01);
  wire       sar_start = state_chg && (next_state == S_CONV);
  wire       sar_abort = (state == S_CONV) && !go;                  // RULE_11

  // Justified result bytes
  wire [7:0] just_hi = timing.justify ? {6'h00, sar_result[9:8]}
                                      : sar_result[9:2];            // RULE_14
  wire [7:0] just_lo = timing.justify ? sar_result[7:0]
                                      : {sar_result[1:0], 6'h00};   // RULE_14

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      S_OFF: begin
        if (conv_on) next_state = S_DISCH;
      end
      S_DISCH: begin
        if (tad_last_disch) next_state = S_SAMPLE;                  // RULE_01
      end
      S_SAMPLE: begin
        if (go) next_state = acq_skip ? S_CONV : S_ACQ;             // RULE_13
      end
      S_ACQ: begin
        if (!go) next_state = S_REST;                               // RULE_11
        else if (tad_last_acq) next_state = S_CONV;                 // RULE_07
      end
      S_CONV: begin
        if (!go || sar_done) next_state = S_REST;                   // RULE_10
      end
      S_REST: begin
        if (tad_last_rest) next_state = S_DISCH;                    // RULE_01
      end
    endcase
    if (!conv_on) next_state = S_OFF;
  end

  // State register and bit period count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= S_OFF;
      tad_cnt <= 5'h00;
    end else begin
      state   <= next_state;
      tad_cnt <= state_chg ? 5'h00 : tad_cnt + {4'h0, tad_tick};
    end
  end

  // Comparator synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_hi_async;
      cmp_sync <= cmp_meta;
    end
  end

  // Bit period clock
  adcts_tad_div u_tad (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (state_chg),
    .div     (div_len),
    .tick    (tad_tick)
  );

  // Conversion engine
  adcts_sar #(.W(RES_WIDTH)) u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (sar_start),
    .abort   (sar_abort),
    .tick    (tad_tick),
    .cmp_hi  (cmp_sync),
    .trial   (sar_trial),
    .result  (sar_result),
    .done    (sar_done)
  );

  // Run control and go flag; a set beats any clear except turning the converter off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_on <= 1'b0;
      go      <= 1'b0;
      chs     <= 4'h0;
    end else begin
      conv_on <= next_on;
      go      <= next_go;                                           // RULE_15
      if (wr && sel_run) chs <= pwdata[RUN_CHS_LSB +: 4];
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinref    <= '0;
      timing    <= '0;
      cmp_mode  <= 4'h0;
      done_mask <= 1'b0;
    end else begin
      if (wr && sel_pin)  pinref    <= pwdata[5:0];
      if (wr && sel_tim)  timing    <= {pwdata[7], pwdata[5:0]};
      if (wr && sel_cmp)  cmp_mode  <= pwdata[3:0];
      if (wr && sel_mask) done_mask <= pwdata[DONE_BIT];
    end
  end

  // Result bytes; a finished conversion beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_hi <= RST_BYTE;
      res_lo <= RST_BYTE;
    end else if (conv_end) begin
      res_hi <= just_hi;                                            // RULE_09
      res_lo <= just_lo;                                            // RULE_09
    end else begin
      if (wr && sel_hi) res_hi <= pwdata[7:0];
      if (wr && sel_lo) res_lo <= pwdata[7:0];
    end
  end

  // Done flag clears on read of the captured bit, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
      irq       <= 1'b0;
    end else begin
      done_flag <= conv_end || (done_flag && !(rd_stat && prdata[DONE_BIT])); // RULE_10
      irq       <= done_flag && done_mask;
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= capture;
      pslverr <= capture && !hit;
      if (capture) prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // Timer clear follows every trigger in compare mode 1011, converter on or off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_clear <= 1'b0;
    end else begin
      timer_clear <= trig_mode;                                     // RULE_04 RULE_05
    end
  end

  // Analog front end controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discharge <= 1'b0;
      sample_en <= 1'b0;
      channel   <= 4'h0;
      vref_sel  <= 2'h0;
      pin_cfg   <= 4'h0;
      dac_code  <= 10'h000;
    end else begin
      discharge <= (next_state == S_DISCH);                         // RULE_01
      sample_en <= (next_state == S_SAMPLE) || (next_state == S_ACQ);
      channel   <= chs;
      vref_sel  <= pinref.vref;
      pin_cfg   <= pinref.pins;
      dac_code  <= sar_trial;
    end
  end

endmodule : adcts_top

// >>> testbench/adcts_chk.sv
// Purpose: Port checks for the converter sequencer.
// Assumes: One clock domain, reset async active low.
// Notes:   Bound to adcts_top by name.
`timescale 1ns/1ns
module adcts_chk
  import adcts_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       special_event,
  input wire logic       timer_clear,
  input wire logic       discharge,
  input wire logic       sample_en,
  input wire logic [9:0] dac_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Sequencer phases
  a_phase_excl: assert property (!(discharge && sample_en))
    else $error("discharge and sampling overlap");
  a_disch_first: assert property ($rose(sample_en) |-> $past(discharge))
    else $error("sampling began without discharge");
  a_dac_hold: assert property ($changed(dac_code) |-> !sample_en)
    else $error("trial code moved while sampling");
  // Timer clear follows an event
  a_clr_cause: assert property (timer_clear |-> $past(special_event))
    else $error("timer clear without event");
  a_clr_pulse: assert property (timer_clear |=> !timer_clear)
    else $error("timer clear longer than one cycle");
  // Register bus answers
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held high");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule : adcts_chk

bind adcts_top adcts_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .special_event(special_event),
  .timer_clear(timer_clear), .discharge(discharge), .sample_en(sample_en),
  .dac_code(dac_code)
);

// >>> testbench/adcts_trig_model.sv
// Purpose: Compare unit trigger, its timer and the analog comparator.
// Assumes: fire is a one-cycle request from the bench.
// Notes:   Comparator offset of half a code makes the result equal level.
`timescale 1ns/1ns
module adcts_trig_model
  import adcts_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic        timer_clear,
  input  wire logic [9:0]  level,
  input  wire logic [9:0]  dac_code,
  output logic             special_event,
  output logic             cmp_hi,
  output logic [15:0]      count
);
  // Input above trial code
  assign cmp_hi = (dac_code <= level);
  // Event pulse and free-running timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_event <= 1'b0;
      count         <= 16'h0000;
    end else begin
      special_event <= fire;
      count         <= timer_clear ? 16'h0000 : count + 16'h0001;
    end
  end
endmodule : adcts_trig_model

// >>> testbench/adc_trigger_sequencer_tb_top.sv
// Purpose: Register level tests of the converter sequencer.
// Assumes: Bit period of 4 cycles (clock codes 100 and RC) in timed tests.
// Notes:   Lengths are checked within a small latency margin.
`timescale 1ns/1ns
module adc_trigger_sequencer_tb_top;
  import adcts_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        fire, special_event, timer_clear, cmp_hi, discharge, sample_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  channel, pin_cfg;
  logic [1:0]  vref_sel;
  logic [9:0]  dac_code, level;
  logic [15:0] tcount;
  logic        e;
  int          fails, n_checks, i, n;

  adcts_top #(.RC_DIV(7'h04)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .special_event(special_event), .timer_clear(timer_clear),
    .cmp_hi_async(cmp_hi), .discharge(discharge), .sample_en(sample_en),
    .channel(channel), .vref_sel(vref_sel), .pin_cfg(pin_cfg), .dac_code(dac_code));
  adcts_trig_model model_u (
    .pclk(pclk), .presetn(presetn), .fire(fire), .timer_clear(timer_clear),
    .level(level), .dac_code(dac_code), .special_event(special_event),
    .cmp_hi(cmp_hi), .count(tcount));

  // Clock
  always #5 pclk = ~pclk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      end_of_test();
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask : rd

  // k 0: sampling off, 1: discharge on, 2: sampling on
  task automatic wait_for(input int k, output int c);
    for (c = 0; c < 500; c++) begin
      if ((k == 0 && sample_en === 1'b0) || (k == 1 && discharge === 1'b1) ||
          (k == 2 && sample_en === 1'b1)) return;
      @(posedge pclk);
    end
    fails++;
    end_of_test();
  endtask : wait_for

  task automatic pulse();
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; fire = 0; level = 10'h2a5; fails = 0; n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, "reset_value");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, e);
    wr(OFS_PINREF, 32'hffffffff);
    rd(OFS_PINREF, 32'h3f, "pinref_bits");
    chk("pin_mirror", 32'h3f, {vref_sel, pin_cfg});
    wr(OFS_TIMING, 32'hff);
    rd(OFS_TIMING, 32'hbf, "timing_bits");
    $display("test registers done");
    // Automatic acquisition, right aligned, interrupt enabled
    wr(OFS_TIMING, 32'h94);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_RUN, 32'h3d);
    wait_for(2, n);
    chk("channel", 32'hf, channel);
    wr(OFS_RUN, 32'h3f);
    wait_for(0, n);
    chk("acq_len", 32'h1, n >= 16 && n <= 20);
    wait_for(1, n);
    chk("conv_len", 32'h1, n >= 52 && n <= 58);
    chk("irq_set", 32'h1, irq);
    rd(OFS_RES_HI, 32'h02, "res_hi_right");
    rd(OFS_RES_LO, 32'ha5, "res_lo_right");
    rd(OFS_RUN, 32'h3d, "go_cleared");
    rd(OFS_IRQ_STAT, 32'h1, "done_flag");
    rd(OFS_IRQ_STAT, 32'h0, "done_cleared");
    chk("irq_clear", 32'h0, irq);
    wait_for(2, n);
    $display("test conversion done");
    // Compare trigger start, left aligned, masked
    level = 10'h15b;
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_TIMING, 32'h13);
    wr(OFS_CMPMODE, 32'hb);
    pulse();
    chk("timer_reset", 32'h1, tcount < 16'h0008);
    rd(OFS_RUN, 32'h3f, "trig_go");
    wait_for(0, n);
    pulse();
    chk("no_restart", 32'h0, sample_en);
    wait_for(1, n);
    chk("irq_masked", 32'h0, irq);
    rd(OFS_RES_HI, 32'h56, "res_hi_left");
    rd(OFS_RES_LO, 32'hc0, "res_lo_left");
    rd(OFS_IRQ_STAT, 32'h1, "trig_done");
    wait_for(2, n);
    $display("test trigger done");
    // Trigger refused by mode and by converter off
    wr(OFS_CMPMODE, 32'ha);
    pulse();
    chk("mode_gate_timer", 32'h1, tcount >= 16'h0008);
    rd(OFS_RUN, 32'h3d, "mode_gate_go");
    wr(OFS_CMPMODE, 32'hb);
    wr(OFS_RUN, 32'h3c);
    pulse();
    chk("off_timer", 32'h1, tcount < 16'h0008);
    rd(OFS_RUN, 32'h3c, "off_go");
    $display("test refusal done");
    // Manual start then abort keeps old result
    level = 10'h3ff;
    wr(OFS_TIMING, 32'h84);
    wr(OFS_RUN, 32'h01);
    wait_for(2, n);
    wr(OFS_RUN, 32'h03);
    wait_for(0, n);
    chk("manual_start", 32'h1, n <= 2);
    wr(OFS_RUN, 32'h01);
    wait_for(1, n);
    rd(OFS_RES_HI, 32'h56, "abort_hi");
    rd(OFS_RES_LO, 32'hc0, "abort_lo");
    rd(OFS_IRQ_STAT, 32'h0, "abort_flag");
    $display("test abort done");
    end_of_test();
  end
endmodule : adc_trigger_sequencer_tb_top
